// *** verilog/gfp_pkg.sv ***
// package: register map, field layout and filter timing for the pin block
package gfp_pkg;

  localparam int          NUM_PINS     = 5;
  localparam int          ADDR_W       = 16;
  localparam int          TICK_W       = 16;

  // register byte addresses
  localparam logic [15:0] PIN1_OFS     = 16'h0c00;
  localparam logic [15:0] PIN2_OFS     = 16'h0c20;
  localparam logic [15:0] PIN3_OFS     = 16'h0c24;
  localparam logic [15:0] PIN4_OFS     = 16'h0c28;
  localparam logic [15:0] PIN5_OFS     = 16'h0c04;
  localparam logic [15:0] FILT_OFS     = 16'h0c10;
  localparam logic [15:0] EVENT_OFS    = 16'h0c30;

  // pin control fields
  localparam int          DIR_BIT      = 15;
  localparam int          PU_BIT       = 14;
  localparam int          PD_BIT       = 13;
  localparam int          LVL_BIT      = 11;
  localparam int          POL_BIT      = 10;
  localparam int          OD_BIT       = 9;
  localparam int          DB_BIT       = 8;
  localparam int          FN_MSB       = 6;
  localparam int          FT_LSB       = 12;
  localparam int          FT_MSB       = 15;

  localparam logic        DIR_RST      = 1'b1;
  localparam logic        PU_RST       = 1'b0;
  localparam logic        PD_RST       = 1'b1;
  localparam logic        LVL_RST      = 1'b0;
  localparam logic        POL_RST      = 1'b0;
  localparam logic        OD_RST       = 1'b0;
  localparam logic        DB_RST       = 1'b1;
  localparam logic [6:0]  FN_RST       = 7'h01;
  localparam logic [3:0]  FT_RST       = 4'h1;
  localparam logic [3:0]  FT_MAX       = 4'ha;

  // function codes
  localparam logic [6:0]  FN_TXFRAME   = 7'h00;
  localparam logic [6:0]  FN_LOGIC     = 7'h01;
  localparam logic [6:0]  FN_INTERRUPT_REQUEST_ONE      = 7'h02;
  localparam logic [6:0]  FN_INTERRUPT_REQUEST_TWO      = 7'h03;
  localparam logic [6:0]  FN_DCLK      = 7'h04;
  localparam logic [6:0]  FN_LL1CLK    = 7'h05;
  localparam logic [6:0]  FN_LL2CLK    = 7'h06;
  localparam logic [6:0]  FN_PULSE_WIDTH_OUT_ONE      = 7'h08;
  localparam logic [6:0]  FN_PULSE_WIDTH_OUT_TWO      = 7'h09;
  localparam logic [6:0]  FN_SYSUC     = 7'h0a;
  localparam logic [6:0]  FN_SECUC     = 7'h0b;
  localparam logic [6:0]  FN_LL1LOCK   = 7'h0c;
  localparam logic [6:0]  FN_LL2LOCK   = 7'h0d;
  localparam logic [6:0]  FN_LL1OK     = 7'h0f;
  localparam logic [6:0]  FN_LL2OK     = 7'h10;
  localparam logic [6:0]  FN_HPDET     = 7'h12;
  localparam logic [6:0]  FN_PIN5_MAX  = 7'h09;
  localparam int          TX_FRAME_PINS = 3;

  // filter times in microseconds, codes 0h..Ah
  localparam longint      FILT_US [11] = '{100, 1500, 3000, 6000, 12000,
                                           24000, 48000, 96000, 192000,
                                           384000, 768000};
  localparam longint      US_PER_S     = 1000000;

  // filter clock ticks for a code, rounded up, never below one
  function automatic logic [TICK_W-1:0] gfp_ticks(input logic [3:0] code,
                                                  input longint    hz);
    longint t;
    t = (FILT_US[(code > FT_MAX) ? FT_MAX : code] * hz + US_PER_S - 1)
        / US_PER_S;
    if (t < 1) t = 1;
    return t[TICK_W-1:0];
  endfunction : gfp_ticks

endpackage : gfp_pkg

// *** verilog/gfp_port.sv ***
// five-pin function port with apb registers, input filter and edge events
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module gfp_port
  import gfp_pkg::*;
#(
  parameter longint FILTER_CLK_HZ = 32000
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                filter_clock_in,
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic      [NUM_PINS-1:0] pin_out,
  output logic      [NUM_PINS-1:0] pin_oe,
  output logic      [NUM_PINS-1:0] pull_up_on,
  output logic      [NUM_PINS-1:0] pull_down_on,
  input  wire logic [2:0]          tx_frame_clock,
  input  wire logic                interrupt_request_one,
  input  wire logic                interrupt_request_two,
  input  wire logic                derived_clock_output,
  input  wire logic                locked_loop_one_clock,
  input  wire logic                locked_loop_two_clock,
  input  wire logic                pulse_width_out_one,
  input  wire logic                pulse_width_out_two,
  input  wire logic                system_clock_underclocked,
  input  wire logic                secondary_clock_underclocked,
  input  wire logic                locked_loop_one_locked,
  input  wire logic                locked_loop_two_locked,
  input  wire logic                locked_loop_one_clock_ok,
  input  wire logic                locked_loop_two_clock_ok,
  input  wire logic                headphone_detect_done,
  output logic      [NUM_PINS-1:0] pin_level_filtered,
  output logic      [NUM_PINS-1:0] pin_event,
  output logic                     pin_five_level
);

  // elaboration check on the filter clock rate
  // upper bound: longest filter time must fit the tick counter
  if (FILTER_CLK_HZ < 1000 || FILTER_CLK_HZ > 85000) begin : g_bad_hz
    $error("gfp_port: FILTER_CLK_HZ out of range");
  end

  // per-pin control state
  logic [NUM_PINS-1:0] dir_q;
  logic [NUM_PINS-1:0] pu_q;
  logic [NUM_PINS-1:0] pd_q;
  logic [NUM_PINS-1:0] lvl_q;
  logic [NUM_PINS-1:0] pol_q;
  logic [NUM_PINS-1:0] od_q;
  logic [NUM_PINS-1:0] db_q;
  logic [6:0]          fn_q [NUM_PINS];
  logic [3:0]          ftime_q;

  // synchronisers, filter and events
  logic [NUM_PINS-1:0] pin_s1_q;
  logic [NUM_PINS-1:0] pin_s2_q;
  logic [NUM_PINS-1:0] filt_q;
  logic [NUM_PINS-1:0] filt_d;
  logic [NUM_PINS-1:0] evt_q;
  logic [TICK_W-1:0]   cnt_q [NUM_PINS];
  logic [TICK_W-1:0]   thr;
  logic                fck_s1_q;
  logic                fck_s2_q;
  logic                fck_s3_q;
  logic                tick;

  // bus decode
  logic                setup;
  logic                wr_en;
  logic [NUM_PINS-1:0] pin_hit;
  logic                filt_hit;
  logic                evt_hit;
  logic                any_hit;
  logic [31:0]         rd_data;
  logic [15:0]         pin_word [NUM_PINS];
  logic [15:0]         pin_ofs  [NUM_PINS];
  logic [NUM_PINS-1:0] src_val;
  logic [4:0]          txf;

  assign pin_ofs[0] = PIN1_OFS;
  assign pin_ofs[1] = PIN2_OFS;
  assign pin_ofs[2] = PIN3_OFS;
  assign pin_ofs[3] = PIN4_OFS;
  assign pin_ofs[4] = PIN5_OFS;

  assign txf      = {2'b00, tx_frame_clock};
  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pready & pwrite & ~pslverr;
  assign filt_hit = (paddr == FILT_OFS);
  assign evt_hit  = (paddr == EVENT_OFS);
  assign any_hit  = (|pin_hit) | filt_hit | evt_hit;
  assign thr      = gfp_ticks(ftime_q, FILTER_CLK_HZ);

  // filter clock is free-running and slow: sample it and find its edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fck_s1_q <= 1'b0;
      fck_s2_q <= 1'b0;
      fck_s3_q <= 1'b0;
    end else begin
      fck_s1_q <= filter_clock_in;
      fck_s2_q <= fck_s1_q;
      fck_s3_q <= fck_s2_q;
    end
  end
  assign tick = fck_s2_q & ~fck_s3_q;

  // pin input synchronisers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dir_q   <= {NUM_PINS{DIR_RST}};
      pu_q    <= {NUM_PINS{PU_RST}};
      pd_q    <= {NUM_PINS{PD_RST}};
      lvl_q   <= {NUM_PINS{LVL_RST}};
      pol_q   <= {NUM_PINS{POL_RST}};
      od_q    <= {NUM_PINS{OD_RST}};
      db_q    <= {NUM_PINS{DB_RST}};
      ftime_q <= FT_RST;
      for (int i = 0; i < NUM_PINS; i++) begin
        fn_q[i] <= FN_RST;
      end
    end else if (wr_en) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (pin_hit[i]) begin
          dir_q[i] <= pwdata[DIR_BIT];
          pu_q[i]  <= pwdata[PU_BIT];
          pd_q[i]  <= pwdata[PD_BIT];
          lvl_q[i] <= pwdata[LVL_BIT];
          pol_q[i] <= pwdata[POL_BIT];
          od_q[i]  <= pwdata[OD_BIT];
          db_q[i]  <= pwdata[DB_BIT];
          fn_q[i]  <= pwdata[FN_MSB:0];
        end
      end
      if (filt_hit) begin
        ftime_q <= pwdata[FT_MSB:FT_LSB];
      end
    end
  end

  // per-pin filter, output select and read word
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    logic v;

    // with db set, filtered level moves only after the input stays put for thr ticks
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        cnt_q[g] <= '0;
      end else if (!db_q[g] || pin_s2_q[g] == filt_q[g]) begin
        cnt_q[g] <= '0;
      end else if (tick) begin
        cnt_q[g] <= (cnt_q[g] + 1'b1 >= thr) ? '0 : cnt_q[g] + 1'b1;
      end
    end

    always_comb begin
      filt_d[g] = filt_q[g];
      if (!db_q[g]) begin
        filt_d[g] = pin_s2_q[g];
      end else if (tick && pin_s2_q[g] != filt_q[g]
                   && cnt_q[g] + 1'b1 >= thr) begin
        filt_d[g] = pin_s2_q[g];
      end
    end

    // source selected by the function code; unlisted codes give low before the polarity bit
    always_comb begin
      v = 1'b0;
      unique case (fn_q[g])
        FN_TXFRAME: v = (g < TX_FRAME_PINS) ? txf[g] : 1'b0;
        FN_LOGIC:   v = lvl_q[g];
        FN_INTERRUPT_REQUEST_ONE:    v = interrupt_request_one;
        FN_INTERRUPT_REQUEST_TWO:    v = interrupt_request_two;
        FN_DCLK:    v = derived_clock_output;
        FN_LL1CLK:  v = locked_loop_one_clock;
        FN_LL2CLK:  v = locked_loop_two_clock;
        FN_PULSE_WIDTH_OUT_ONE:    v = pulse_width_out_one;
        FN_PULSE_WIDTH_OUT_TWO:    v = pulse_width_out_two;
        FN_SYSUC:   v = system_clock_underclocked;
        FN_SECUC:   v = secondary_clock_underclocked;
        FN_LL1LOCK: v = locked_loop_one_locked;
        FN_LL2LOCK: v = locked_loop_two_locked;
        FN_LL1OK:   v = locked_loop_one_clock_ok;
        FN_LL2OK:   v = locked_loop_two_clock_ok;
        FN_HPDET:   v = headphone_detect_done;
        default:    v = 1'b0;
      endcase
      // pin five carries only the low codes
      if (g == NUM_PINS - 1 && fn_q[g] > FN_PIN5_MAX) begin
        v = 1'b0;
      end
      src_val[g] = v ^ pol_q[g];
    end

    // level bit reads back filtered input, zero while an output
    assign pin_word[g] = {dir_q[g], pu_q[g], pd_q[g], 1'b0,
                          dir_q[g] & filt_q[g],
                          pol_q[g], od_q[g], db_q[g], 1'b0, fn_q[g]};
    assign pin_hit[g]  = (paddr == pin_ofs[g]);
  end

  // filtered level and latched edge events; set wins over clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      filt_q <= '0;
      evt_q  <= '0;
    end else begin
      filt_q <= filt_d;
      evt_q  <= (evt_q & ~({NUM_PINS{wr_en & evt_hit}}
                           & pwdata[NUM_PINS-1:0]))
                | (filt_d ^ filt_q);
    end
  end

  // pad drive: registered so clocks pass with one cycle of skew
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_out      <= '0;
      pin_oe       <= '0;
      pull_up_on   <= '0;
      pull_down_on <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        // open drain only pulls low, high is released with pull_up_on off while the pin is an output
        pin_out[i]      <= od_q[i] ? 1'b0 : src_val[i];
        pin_oe[i]       <= ~dir_q[i] & (~od_q[i] | ~src_val[i]);
        pull_up_on[i]   <= dir_q[i] & pu_q[i] & ~pd_q[i];
        pull_down_on[i] <= dir_q[i] & pd_q[i] & ~pu_q[i];
      end
    end
  end

  // filtered levels and events toward wake and interrupt logic
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_level_filtered <= '0;
      pin_event          <= '0;
      pin_five_level     <= 1'b0;
    end else begin
      pin_level_filtered <= filt_q;
      pin_event          <= evt_q;
      pin_five_level     <= filt_q[NUM_PINS-1];
    end
  end

  // read mux
  always_comb begin
    rd_data = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_hit[i]) begin
        rd_data = {16'h0000, pin_word[i]};
      end
    end
    if (filt_hit) begin
      rd_data = {16'h0000, ftime_q, 12'h000};
    end
    if (evt_hit) begin
      rd_data = {27'h0000000, evt_q};
    end
  end

  // apb slave: one wait-free access phase, error on unmapped address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~any_hit;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_data;
      end
    end
  end

endmodule : gfp_port

// *** verification/gfp_chk.sv ***
// checker for the five-pin function port
`timescale 1ns/1ps
module gfp_chk
  import gfp_pkg::*;
(
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] pull_up_on,
  input wire logic [NUM_PINS-1:0] pull_down_on,
  input wire logic [NUM_PINS-1:0] pin_level_filtered,
  input wire logic [NUM_PINS-1:0] pin_event,
  input wire logic                pin_five_level
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // mirror may lag the clear write by two cycles
  logic [1:0] clr_q;
  wire        clr = psel & penable & pwrite & (paddr == EVENT_OFS);
  always_ff @(posedge clock) begin
    if (!rst_n) clr_q <= 2'h0;
    else clr_q <= {clr_q[0], clr};
  end
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (psel && penable && pready
    && paddr == 16'h0c08 |-> pslverr) else $error("no error on hole");
  a_out_no_pull: assert property ((pin_oe & (pull_up_on | pull_down_on))
    == '0) else $error("pull on driven pin");
  a_pull_excl: assert property ((pull_up_on & pull_down_on) == '0)
    else $error("both pulls on");
  a_event_hold: assert property ((($past(pin_event) & ~pin_event) != '0)
    |-> clr_q != 2'h0) else $error("event lost");
  a_event_sets: assert property (pin_level_filtered !=
    $past(pin_level_filtered) |-> ##[0:2] pin_event != '0)
    else $error("edge raised no event");
  a_five_level: assert property (pin_five_level == pin_level_filtered[4]
    || pin_five_level == $past(pin_level_filtered[4]))
    else $error("pin five level wrong");
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |=>
    pin_oe == '0 && pin_event == '0) else $error("reset state");
  c_event: cover property (pin_event != '0);
  c_slverr: cover property (pslverr);
  c_drive: cover property (pin_oe != '0 && pin_out != '0);
endmodule : gfp_chk

bind gfp_port gfp_chk chk (.*);

// *** verification/gfp_ext.sv ***
// pad model: outside switches, pulls and floating pads
`timescale 1ns/1ps
module gfp_ext (
  input  wire logic       clock,
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  input  wire logic [4:0] pull_up_on,
  input  wire logic [4:0] pull_down_on,
  input  wire logic [4:0] xen,
  input  wire logic [4:0] xval,
  output logic      [4:0] pin_in
);
  // a floating pad flips each cycle so no stale level is seen
  logic [4:0] last_q = 5'h0;
  always_ff @(posedge clock) last_q <= pin_in;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (xen[i]) pin_in[i] = xval[i];
      else if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (pull_up_on[i]) pin_in[i] = 1'b1;
      else if (pull_down_on[i]) pin_in[i] = 1'b0;
      else pin_in[i] = ~last_q[i];
    end
  end
endmodule : gfp_ext

// *** verification/gfp_port_test.sv ***
// self-checking bench for the five-pin function port
`timescale 1ns/1ps
module gfp_port_test;
  import gfp_pkg::*;
  logic        clock = 0, rst_n = 0, filter_clock_in = 0;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, w;
  logic [4:0]  pin_in, pin_out, pin_oe, pull_up_on, pull_down_on;
  logic [4:0]  pin_level_filtered, pin_event, xen = 0, xval = 0;
  logic        pin_five_level, e;
  logic [16:0] src = 0;
  logic [2:0]  v;
  int          num_errors = 0, total_checks = 0, seed = 32'hb28c, r;
  logic [15:0] ofs [5] = '{PIN1_OFS, PIN2_OFS, PIN3_OFS, PIN4_OFS,
                           PIN5_OFS};
  gfp_port uut (.*, .tx_frame_clock(src[2:0]),
    .interrupt_request_one(src[3]), .interrupt_request_two(src[4]),
    .derived_clock_output(src[5]), .locked_loop_one_clock(src[6]),
    .locked_loop_two_clock(src[7]), .pulse_width_out_one(src[8]),
    .pulse_width_out_two(src[9]), .system_clock_underclocked(src[10]),
    .secondary_clock_underclocked(src[11]),
    .locked_loop_one_locked(src[12]), .locked_loop_two_locked(src[13]),
    .locked_loop_one_clock_ok(src[14]),
    .locked_loop_two_clock_ok(src[15]), .headphone_detect_done(src[16]));
  gfp_ext ext (.*);
  initial forever #20 clock = ~clock;
  // filter clock at a sixth of the bus clock keeps runs short, still well below the sync rate
  initial forever begin
    repeat (3) @(posedge clock);
    filter_clock_in <= ~filter_clock_in;
  end
  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) num_errors++;
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  // expected pin value of function f before inversion
  function automatic logic sel(int p, logic [6:0] f, logic l);
    case (f)
      7'h00: return (p < 3) ? src[p] : 1'b0;
      7'h01: return l;
      7'h02, 7'h03, 7'h04, 7'h05, 7'h06: return src[f + 1];
      7'h08, 7'h09: return src[f];
      7'h0a, 7'h0b, 7'h0c, 7'h0d: return p < 4 && src[f];
      7'h0f, 7'h10: return p < 4 && src[f - 1];
      7'h12: return p < 4 && src[16];
      default: return 1'b0;
    endcase
  endfunction : sel
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (30000) @(posedge clock);
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1;
    for (int i = 0; i < 5; i++) begin
      apb(0, ofs[i], 0);
      chk(rd, 32'ha101);
    end
    chk({pull_up_on, pull_down_on}, 32'h1f);
    apb(0, FILT_OFS, 0);
    chk(rd, 32'h1000);
    for (int p = 0; p < 5; p++) begin
      for (int f = 0; f < 19; f++) begin
        r = $random(seed);
        src <= r[16:0];
        v = r[19:17];
        w = {20'h0, v, 2'b00, f[6:0]};
        apb(1, ofs[p], w);
        repeat (3) @(posedge clock);
        e = sel(p, f[6:0], v[2]) ^ v[1];
        chk({pin_oe[p], pin_out[p]}, v[0] ? {~e, 1'b0} : {1'b1, e});
        apb(0, ofs[p], 0);
        chk(rd, w & 32'hf7ff);
      end
    end
    apb(1, FILT_OFS, 0);
    apb(1, PIN1_OFS, 32'he101);
    repeat (2) @(posedge clock);
    chk({pull_up_on[0], pull_down_on[0]}, 0);
    for (int i = 0; i < 5; i++) apb(1, ofs[i], 32'ha101);
    repeat (100) @(posedge clock);
    apb(1, EVENT_OFS, 32'h1f);
    apb(1, PIN5_OFS, 32'hc401);
    repeat (20) @(posedge clock);
    apb(0, PIN5_OFS, 0);
    chk(rd, 32'hcc01);
    chk(pin_five_level, 1);
    chk(pin_level_filtered, 5'h10);
    apb(0, EVENT_OFS, 0);
    chk(rd, 32'h10);
    chk(pin_event, 5'h10);
    xen[4] <= 1;
    apb(1, PIN5_OFS, 32'hc501);
    repeat (60) @(posedge clock);
    apb(1, EVENT_OFS, 32'h10);
    xval[4] <= 1;
    repeat (12) @(posedge clock);
    xval[4] <= 0;
    repeat (60) @(posedge clock);
    apb(0, EVENT_OFS, 0);
    chk(rd, 0);
    xval[4] <= 1;
    repeat (60) @(posedge clock);
    apb(0, PIN5_OFS, 0);
    chk(rd, 32'hcd01);
    apb(0, EVENT_OFS, 0);
    chk(rd, 32'h10);
    apb(1, EVENT_OFS, 32'h10);
    apb(0, EVENT_OFS, 0);
    chk(rd, 0);
    apb(0, 16'h0c08, 0);
    chk(err, 1);
    chk(rd, 0);
    wrap_up();
  end
endmodule : gfp_port_test
